//--- srs_pkg.sv
// Overview of operation
// [RQ1] host holds reset low at least 750ns
// [RQ2] device outputs defined while reset held low
// [RQ3] reset never enters a low-power state
// [RQ4] host waits 10 clock edges before serial
// [RQ5] device finishes current frame, then enters standby
// [RQ6] host keeps clock running through frame finish
// [RQ7] standby floats video and sync outputs; line_valid_o has no output enable and is driven low
// [RQ8] standby keeps serial control port silent
// [RQ9] dead-zone standby request may lock standby
// [RQ10] hardware reset clears permanent standby
// [RQ11] host may request during frame active, hold frame
// [RQ12] host may request at frame fall, hold 5+vblank
// [RQ13] host never toggles request near vblank plus/minus 5
package srs_pkg;
   localparam int  CLK_PERIOD_NS   = 50;
   localparam int  RESET_MIN_NS    = 750;
   localparam int  RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  SER_WAIT_EDGES  = 10;
   localparam int  VB_GUARD_ROWS   = 5;
   localparam int  ROW_CYC         = 16;
   localparam int  ACT_ROWS        = 8;
   localparam int  VBLANK_RST      = 4;
   localparam int  DATA_W          = 10;
   localparam int  CNT_W           = 16;
endpackage

//--- srs_if.sv
`timescale 1ns/1ps
// pins between host and sensor; the wire levels are driven by the host and sensor modules
interface srs_if;
   logic                        rst_n;         // hardware reset, active low
   logic                        standby_req;   // standby request
   logic                        serial_en;     // host wants serial access
   logic                        serial_ack;    // device answers serial port
   logic                        frame_valid_o; // frame active
   logic                        frame_valid_oe_n;
   logic                        line_valid_o;
   logic [srs_pkg::DATA_W-1:0]  pix_o;
   logic                        pix_oe_n;      // low while driving
   logic                        in_standby;
   modport dev  (input rst_n, standby_req, serial_en,
                 output serial_ack, frame_valid_o, frame_valid_oe_n, line_valid_o, pix_o, pix_oe_n, in_standby);
   modport host (output rst_n, standby_req, serial_en,
                 input serial_ack, frame_valid_o, frame_valid_oe_n, line_valid_o, pix_o, pix_oe_n, in_standby);
endinterface

//--- srs_sensor.sv
`timescale 1ns/1ps
// sensor end: frame timing generator with standby sequencing
module srs_sensor #(
   parameter int ROW_CYC  = srs_pkg::ROW_CYC,
   parameter int ACT_ROWS = srs_pkg::ACT_ROWS
) (
   input  wire logic                ref_clk,
   srs_if.dev                       pins,
   input  wire logic [7:0]          vblank_rows_reg,
   output logic                     power_low
);
   typedef enum logic [2:0] {
      SS_ACTIVE  = 3'b001,
      SS_BLANK   = 3'b010,
      SS_STANDBY = 3'b100
   } srs_st_e;

   typedef struct packed {
      srs_st_e                      st;
      logic [srs_pkg::CNT_W-1:0]    col;
      logic [srs_pkg::CNT_W-1:0]    row;
      logic                         pend;      // request seen, frame still running
      logic                         locked;    // dead-zone lock
      logic [1:0]                   req_sync;
      logic [1:0]                   ser_sync;
      logic [srs_pkg::DATA_W-1:0]   pix;
   } srs_dev_s;

   srs_dev_s s_q, s_d;
   logic     resetn;
   logic     req, row_end, dead_zone;

   assign resetn    = pins.rst_n;
   assign req       = s_q.req_sync[1];
   assign row_end   = (s_q.col == srs_pkg::CNT_W'(ROW_CYC - 1));
   // dead zone: last row of blanking, just before readout restarts
   assign dead_zone = (s_q.st == SS_BLANK) && (s_q.row + 16'h0001 == {8'h00, vblank_rows_reg});

   always_comb begin
      s_d          = s_q;
      s_d.req_sync = {s_q.req_sync[0], pins.standby_req};
      s_d.ser_sync = {s_q.ser_sync[0], pins.serial_en};
      s_d.col      = row_end ? '0 : s_q.col + 16'h0001;
      if (s_q.st != SS_ACTIVE && s_q.st != SS_STANDBY)
         s_d.pix = '0;
      else
         s_d.pix = s_q.pix + 10'h001;
      case (s_q.st)
         SS_ACTIVE: begin
            if (req)
               s_d.pend = 1'b1;
            if (row_end) begin
               s_d.row = s_q.row + 16'h0001;
               if (s_q.row == srs_pkg::CNT_W'(ACT_ROWS - 1)) begin
                  s_d.row = '0;
                  // finish the frame first, then sleep
                  if (s_q.pend || req)    // RQ5
                     s_d.st = SS_STANDBY;
                  else
                     s_d.st = SS_BLANK;
               end
            end
         end
         SS_BLANK: begin
            if (req && !s_q.pend && dead_zone)
               s_d.locked = 1'b1;         // RQ9
            if (req)
               s_d.pend = 1'b1;
            if (row_end) begin
               s_d.row = s_q.row + 16'h0001;
               if (s_q.row + 16'h0001 >= {8'h00, vblank_rows_reg}) begin
                  s_d.row = '0;
                  s_d.st  = (s_q.pend || req) ? SS_STANDBY : SS_ACTIVE;
               end
            end
         end
         SS_STANDBY: begin
            s_d.pend = 1'b0;
            s_d.col  = '0;
            // a locked device ignores release; only reset helps
            if (!req && !s_q.locked) begin // RQ9
               s_d.st  = SS_ACTIVE;
               s_d.row = '0;
            end
         end
         default: s_d.st = SS_STANDBY;
      endcase
   end

   // reset returns default startup state without any low-power mode
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         s_q <= '{st: SS_BLANK, default: '0}; // RQ10
      else
         s_q <= s_d;
   end

   // outputs defined under reset even without clock: all from constants
   always_comb begin
      pins.in_standby       = (s_q.st == SS_STANDBY);
      pins.pix_oe_n         = pins.in_standby;         // RQ7
      pins.frame_valid_oe_n = pins.in_standby;         // RQ7
      pins.frame_valid_o    = (s_q.st == SS_ACTIVE);   // RQ2
      pins.line_valid_o     = (s_q.st == SS_ACTIVE) && (s_q.col < 16'(ROW_CYC - 2));
      pins.pix_o            = s_q.pix;
      pins.serial_ack       = s_q.ser_sync[1] && !pins.in_standby; // RQ8
      power_low             = pins.in_standby;         // RQ3
   end
endmodule

//--- srs_host.sv
`timescale 1ns/1ps
// host end: power-up reset, serial wait, safe standby entry
module srs_host (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   srs_if.host              pins,
   input  wire logic        sleep_cmd,
   input  wire logic        serial_cmd,
   input  wire logic [7:0]  vblank_rows_reg,
   output logic             serial_ready,
   output logic             asleep
);
   typedef enum logic [3:0] {
      HS_RESET = 4'b0001,
      HS_WAIT  = 4'b0010,
      HS_RUN   = 4'b0100,
      HS_HOLD  = 4'b1000
   } srs_hst_e;

   typedef struct packed {
      srs_hst_e     st;
      logic [15:0]  cnt;
      logic [1:0]   fv_sync;
      logic         fv_last;
      logic         rst_n;
      logic         req;
      logic         whole;     // request made mid-frame, hold a whole frame
   } srs_host_s;

   srs_host_s h_q, h_d;
   logic      fv, fv_fall;
   logic [15:0] hold_cyc;
   logic [15:0] frame_cyc;
   logic [15:0] hold_lim;

   assign fv       = h_q.fv_sync[1];
   assign fv_fall  = h_q.fv_last && !fv;
   // hold 5 + vblank rows, measured in clocks
   assign hold_cyc = 16'((32'(vblank_rows_reg) + srs_pkg::VB_GUARD_ROWS) * srs_pkg::ROW_CYC);
   // one full frame period, for requests made while the frame is active
   assign frame_cyc = 16'((32'(vblank_rows_reg) + srs_pkg::ACT_ROWS) * srs_pkg::ROW_CYC);
   assign hold_lim  = h_q.whole ? frame_cyc : hold_cyc;

   always_comb begin
      h_d         = h_q;
      h_d.fv_sync = {h_q.fv_sync[0], pins.frame_valid_o && !pins.frame_valid_oe_n};
      h_d.fv_last = fv;
      h_d.cnt     = h_q.cnt + 16'h0001;
      case (h_q.st)
         HS_RESET: begin
            h_d.rst_n = 1'b0;
            if (h_q.cnt >= 16'(srs_pkg::RESET_MIN_CYC - 1)) begin // RQ1
               h_d.st    = HS_WAIT;
               h_d.rst_n = 1'b1;
               h_d.cnt   = '0;
            end
         end
         HS_WAIT: begin
            if (h_q.cnt >= 16'(srs_pkg::SER_WAIT_EDGES)) // RQ4
               h_d.st = HS_RUN;
         end
         HS_RUN: begin
            // request on the frame fall or while the frame is active, never mid-blanking
            if (sleep_cmd && fv_fall) begin // RQ12
               h_d.req   = 1'b1;
               h_d.st    = HS_HOLD;
               h_d.cnt   = '0;
               h_d.whole = 1'b0;
            end else if (sleep_cmd && fv) begin // RQ11
               h_d.req   = 1'b1;
               h_d.st    = HS_HOLD;
               h_d.cnt   = '0;
               h_d.whole = 1'b1;
            end
         end
         HS_HOLD: begin
            // no release inside the guard window; clock keeps running
            if (h_q.cnt >= hold_lim && !sleep_cmd) begin // RQ13
               h_d.req = 1'b0;
               h_d.st  = HS_RUN;
            end
            if (h_q.cnt >= hold_lim)
               h_d.cnt = hold_lim;                     // RQ6
         end
         default: h_d.st = HS_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         h_q <= '{st: HS_RESET, default: '0};
      else
         h_q <= h_d;
   end

   assign pins.rst_n       = h_q.rst_n;
   assign pins.standby_req = h_q.req;
   assign pins.serial_en   = serial_cmd && (h_q.st == HS_RUN);
   assign serial_ready     = (h_q.st == HS_RUN);
   assign asleep           = pins.in_standby;
endmodule

//--- srs_monitor.sv
`timescale 1ns/1ps
// watches the pins between host and sensor ends
module srs_monitor (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic standby_req,
   input wire logic serial_en,
   input wire logic serial_ack,
   input wire logic frame_valid_o,
   input wire logic frame_valid_oe_n,
   input wire logic line_valid_o,
   input wire logic pix_oe_n,
   input wire logic in_standby
);
   logic [7:0] low_q = 8'h00;
   logic [7:0] up_q  = 8'h00;
   default clocking @(posedge ref_clk); endclocking
   // edges in reset and since release; saturate so long runs never wrap
   always @(posedge ref_clk) begin
      low_q <= rst_n ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
      up_q  <= !rst_n ? 8'h00 : up_q + {7'h00, up_q != 8'hff};
   end
   sequence sleep_entry;
      !in_standby ##1 in_standby;
   endsequence
   float_pins_a: assert property (disable iff (!rst_n) in_standby |-> pix_oe_n && frame_valid_oe_n)
      else $error("outputs driven in standby");
   serial_quiet_a: assert property (disable iff (!rst_n) in_standby |-> !serial_ack)
      else $error("serial answered in standby");
   // the last clock of a frame still has frame active high, but the line has already ended
   frame_done_a: assert property (disable iff (!rst_n) sleep_entry |-> !$past(line_valid_o) && $past(standby_req, 2))
      else $error("standby entered mid frame or unasked");
   no_frame_a: assert property (disable iff (!rst_n) in_standby |-> !frame_valid_o)
      else $error("frame active in standby");
   reset_width_a: assert property ($rose(rst_n) |-> low_q >= srs_pkg::RESET_MIN_CYC)
      else $error("reset pulse too short");
   serial_wait_a: assert property (disable iff (!rst_n) $rose(serial_en) |-> up_q >= srs_pkg::SER_WAIT_EDGES)
      else $error("serial access too soon");
   wake_reset_a: assert property ($rose(rst_n) |-> !in_standby ##1 !in_standby)
      else $error("standby kept across reset");
   reset_drive_a: assert property (!rst_n ##1 !rst_n |-> !pix_oe_n && !in_standby)
      else $error("outputs undefined in reset");
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
   logic       ref_clk;
   logic       resetn;
   logic       sleep_cmd;
   logic       serial_cmd;
   logic [7:0] vblank_rows_reg;
   logic       serial_ready;
   logic       asleep;
   logic       power_low;
   int         fails;
   int         check_count;
   int         cyc;
   // each row: blanking rows, then expected float level while asleep
   logic [8:0] rows [3] = '{9'h005, 9'h009, 9'h00d};
   srs_if pins_if();
   srs_host srs_host_i (.ref_clk(ref_clk), .resetn(resetn), .pins(pins_if.host), .sleep_cmd(sleep_cmd),
      .serial_cmd(serial_cmd), .vblank_rows_reg(vblank_rows_reg), .serial_ready(serial_ready), .asleep(asleep));
   srs_sensor srs_sensor_i (.ref_clk(ref_clk), .pins(pins_if.dev), .vblank_rows_reg(vblank_rows_reg),
      .power_low(power_low));
   srs_monitor srs_monitor_i (.ref_clk(ref_clk), .rst_n(pins_if.rst_n), .standby_req(pins_if.standby_req),
      .serial_en(pins_if.serial_en), .serial_ack(pins_if.serial_ack), .frame_valid_o(pins_if.frame_valid_o),
      .frame_valid_oe_n(pins_if.frame_valid_oe_n), .line_valid_o(pins_if.line_valid_o),
      .pix_oe_n(pins_if.pix_oe_n), .in_standby(pins_if.in_standby));
   task automatic end_sim();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   // sample on falling edges so the rising-edge updates have landed
   task automatic wait_lvl(input logic lvl);
      int n;
      n = 0;
      while ((pins_if.in_standby !== lvl || asleep !== lvl) && n < 1000) begin
         @(negedge ref_clk);
         n++;
      end
      cmp(pins_if.in_standby, lvl, "standby level");
      cmp(asleep, lvl, "asleep level");
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // a hang counts as a mismatch; tests need about a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      resetn = 1'b0;
      sleep_cmd = 1'b0;
      serial_cmd = 1'b1;
      vblank_rows_reg = 8'h04;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (6) @(negedge ref_clk);
      cmp(pins_if.pix_oe_n, 1'b0, "pixels float in reset");
      cmp(power_low, 1'b0, "low power in reset");
      repeat (14) @(negedge ref_clk);
      cmp(serial_ready, 1'b0, "serial ready early");
      repeat (40) @(negedge ref_clk);
      cmp(pins_if.serial_ack, 1'b1, "serial not answered");
      $display("power-up test done");
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         vblank_rows_reg <= rows[i][8:1];
         sleep_cmd <= 1'b1;
         wait_lvl(1'b1);
         cmp(pins_if.pix_oe_n, rows[i][0], "pixels driven");
         cmp(pins_if.frame_valid_oe_n, rows[i][0], "sync driven");
         cmp(pins_if.serial_ack, 1'b0, "serial answered");
         @(posedge ref_clk);
         sleep_cmd <= 1'b0;
         wait_lvl(1'b0);
         $display("row %0d done", i);
      end
      @(posedge ref_clk);
      sleep_cmd <= 1'b1;
      wait_lvl(1'b1);
      @(posedge ref_clk);
      resetn <= 1'b0;
      sleep_cmd <= 1'b0;
      repeat (4) @(negedge ref_clk);
      cmp(pins_if.pix_oe_n, 1'b0, "pixels float in reset");
      cmp(power_low, 1'b0, "low power in reset");
      @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (60) @(negedge ref_clk);
      cmp(pins_if.in_standby, 1'b0, "standby after reset");
      $display("reset in standby test done");
      end_sim();
   end
endmodule
